// >>> core/pwr_epoch_pkg.sv
/*
 * constants, register map and state type for the power-state and
 * navigation-epoch timing block.
 * assumes a single 200 MHz clock and an apb master on the register side.
 */
// Summary of operation
// RULE1 - power request forces inactive in any mode
// RULE2 - inactive until timeout or pin wake
// RULE3 - power request overrides power save scheduling
// RULE4 - after wake, power save resumes as configured
// RULE5 - peak current limit applies in all modes
// RULE6 - pin forced-off also works without power save
// RULE7 - continuous mode uses configured measurement period
// RULE8 - power save only with valid measurement period
// RULE9 - power optimized tracking uses measurement period
// RULE10 - cyclic falls back to on/off unless stay-cyclic
// RULE11 - on/off acquisition fixed at 2 Hz
// RULE12 - tracking and other states use configured rate
// RULE13 - software backup via request, behaves like on/off
// RULE14 - divide clock to 1 kHz reference tick
// RULE15 - local time counts ticks in milliseconds
// RULE16 - local time jumps to system time estimate
// RULE17 - solutions start on nearest reference tick
// RULE18 - epochs 1000 ticks, occasionally 999 or 1001
// RULE19 - epoch time converted to gps and utc
// RULE20 - default offsets used, flagged invalid
// RULE21 - wake ignored while already active
// RULE22 - wake pins synchronised before edge detection
`default_nettype none
package pwr_epoch_pkg;
    // clock and reference tick
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int DIV_W = 18;
    // rates in ms
    localparam logic [15:0] ACQ_PERIOD_MS = 16'h01f4;
    localparam logic [15:0] MEASUREMENT_PERIOD_HALF_MS = 16'h01f4;
    localparam logic [15:0] MEASUREMENT_PERIOD_STEP_MS = 16'h03e8;
    localparam int MEASUREMENT_PERIOD_MULT_MAX = 10;
    localparam logic [15:0] MEASUREMENT_PERIOD_RESET = 16'h03e8;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_PMREQ = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TIME = 8'h10;
    localparam logic [7:0] ADDR_DRIFT = 8'h14;
    localparam logic [7:0] ADDR_LEAP = 8'h18;
    localparam logic [7:0] ADDR_GPS = 8'h1c;
    localparam logic [7:0] ADDR_UTC = 8'h20;
    // field positions
    localparam int CTRL_PEAK_BIT = 2;
    localparam int CTRL_STAY_BIT = 3;
    localparam int CTRL_FOFF_BIT = 4;
    localparam int PMREQ_BACKUP_BIT = 31;
    // mode codes
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_ONOFF = 2'h1;
    localparam logic [1:0] MODE_CYCLIC = 2'h2;
    // drift correction codes
    localparam logic [1:0] DRIFT_PLUS = 2'h1;
    localparam logic [1:0] DRIFT_MINUS = 2'h3;
    // default leap offset when no conversion parameters are held
    localparam logic [7:0] LEAP_DEFAULT = 8'h00;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    // wake pin positions in the synchroniser vector
    localparam int PIN_EXT = 0;
    localparam int PIN_RX = 1;
    localparam int PIN_CS = 2;
    localparam int PIN_RSTN = 3;
    typedef enum logic [2:0] {st_cont, st_acq, st_track, st_pot, st_inactive} pwr_state_t;
endpackage
`default_nettype wire

// >>> core/pwr_epoch_ctrl.sv
/*
 * power-state sequencer and 1 kHz epoch timer with apb register slave.
 * assumes pins are asynchronous, fix_available comes from logic on clk.
 */
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
module pwr_epoch_ctrl #(
    parameter int tick_cycles = pwr_epoch_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_interrupt_pin,
    input wire logic serial_rx,
    input wire logic serial_cs_n,
    input wire logic active_low_reset_pin,
    input wire logic fix_available,
    output logic ms_tick,
    output logic nav_epoch,
    output logic receiver_inactive,
    output logic peak_current_limit,
    output logic fixed_rate_2hz
);
    import pwr_epoch_pkg::*;

    // whole block state in one record
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic [31:0] local_ms;
        logic time_valid;
        logic [15:0] epoch_cnt;
        logic epoch;
        logic [1:0] drift;
        logic [31:0] gps_ms;
        logic [31:0] utc_ms;
        logic [7:0] leap;
        logic leap_valid;
        logic [1:0] cfg_mode;
        logic [1:0] eff_mode;
        logic peak;
        logic stay;
        logic foff_en;
        logic [15:0] measurement_period;
        logic cfg_err;
        logic backup;
        logic [23:0] sleep_ms;
        pwr_state_t st;
        logic inactive_o;
        logic fixed_o;
    } regs_t;

    regs_t r; // registered state
    regs_t n; // next state

    // measurement period legal for power save
    function automatic logic measurement_period_ok(input logic [15:0] v);
        logic ok;
        ok = (v == MEASUREMENT_PERIOD_HALF_MS);
        for (int k = 1; k <= MEASUREMENT_PERIOD_MULT_MAX; k++)
        begin
            if (v == 16'(k * 1000))
            begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // change to on/off or cyclic accepted only with a legal period; continuous always, mode 3 never
    function automatic logic ctrl_ok(input logic [1:0] m, input logic [15:0] v);
        return (m == MODE_CONT) || ((m != 2'h3) && measurement_period_ok(v));
    endfunction

    logic [3:0] pin_edge; // any-edge per pin
    logic wake; // wake event seen at pins
    logic ext_fell; // forced-off trigger
    logic active; // acquisition, tracking, pot or continuous
    logic onoff_like; // on/off or software backup behaviour
    logic [15:0] period; // epoch spacing in ticks
    logic [16:0] reload; // period with drift step
    logic access; // apb access phase
    logic taken; // transfer completes this edge
    logic hit; // mapped offset
    logic wr_err; // rejected write
    logic [31:0] utc_calc; // utc from gps minus leap

    // pin edge detection on second-stage and third-stage values only
    always_comb
    begin
        pin_edge = r.sync2 ^ r.prev; // RULE22
        wake = pin_edge[PIN_EXT] | pin_edge[PIN_RX]
            | (r.prev[PIN_CS] & ~r.sync2[PIN_CS])
            | (~r.prev[PIN_RSTN] & r.sync2[PIN_RSTN]); // RULE2
        ext_fell = r.prev[PIN_EXT] & ~r.sync2[PIN_EXT];
        active = (r.st != st_inactive);
        onoff_like = (r.eff_mode == MODE_ONOFF) | r.backup;
        // acquisition in on/off is pinned to 2 Hz, everything else follows config
        if ((r.st == st_acq) && onoff_like)
        begin
            period = ACQ_PERIOD_MS; // RULE11
        end
        else
        begin
            period = r.measurement_period; // RULE7 RULE9 RULE12
        end
        case (r.drift)
            DRIFT_PLUS: reload = {1'b0, period} + 17'h00001; // RULE18
            DRIFT_MINUS: reload = {1'b0, period} - 17'h00001; // RULE18
            default: reload = {1'b0, period};
        endcase
        access = psel & penable;
        taken = access & r.pready;
        hit = (paddr == ADDR_CTRL) || (paddr == ADDR_RATE) || (paddr == ADDR_PMREQ)
            || (paddr == ADDR_STATUS) || (paddr == ADDR_TIME) || (paddr == ADDR_DRIFT)
            || (paddr == ADDR_LEAP) || (paddr == ADDR_GPS) || (paddr == ADDR_UTC);
        wr_err = pwrite && (((paddr == ADDR_CTRL) && !ctrl_ok(pwdata[1:0], r.measurement_period))
            || ((paddr == ADDR_RATE) && (r.eff_mode != MODE_CONT)
            && !measurement_period_ok(pwdata[15:0]))); // RULE8
        // both factors widened first so leap seconds above one never wrap the product
        utc_calc = r.local_ms - (32'(r.leap) * 32'(MS_PER_S)); // RULE19 RULE20
    end

    // next-state logic for the whole block
    always_comb
    begin
        n = r;
        // two-stage synchroniser, third stage for edges
        n.sync1 = {active_low_reset_pin, serial_cs_n, serial_rx, external_interrupt_pin};
        n.sync2 = r.sync1; // RULE22
        n.prev = r.sync2;
        n.tick = 1'b0;
        n.epoch = 1'b0;
        // divider to the 1 kHz reference
        if (r.div_cnt == DIV_W'(tick_cycles - 1))
        begin
            n.div_cnt = '0;
            n.tick = 1'b1; // RULE14
        end
        else
        begin
            n.div_cnt = r.div_cnt + 1'b1;
        end
        // local time runs in ms even while inactive
        if (r.tick)
        begin
            n.local_ms = r.local_ms + 32'h00000001; // RULE15 RULE16
        end
        // epochs land on a tick; drift steps are taken one epoch at a time
        if (r.tick && active)
        begin
            if (r.epoch_cnt <= 16'h0001)
            begin
                n.epoch = 1'b1; // RULE17
                n.epoch_cnt = reload[15:0]; // RULE18
                n.drift = 2'h0;
                n.gps_ms = r.local_ms; // RULE19
                n.utc_ms = utc_calc; // RULE19 RULE20
            end
            else
            begin
                n.epoch_cnt = r.epoch_cnt - 16'h0001;
            end
        end
        // power state machine
        case (r.st)
            st_cont:
            begin
                n.st = st_cont; // RULE21
            end
            st_acq:
            begin
                if (fix_available)
                begin
                    if ((r.eff_mode == MODE_CONT) && r.backup)
                    begin
                        n.st = st_cont;
                        n.backup = 1'b0;
                    end
                    else
                    begin
                        n.st = st_track; // RULE12
                    end
                end
            end
            st_track:
            begin
                // cyclic drops into pot at the next epoch
                if ((r.eff_mode == MODE_CYCLIC) && r.epoch)
                begin
                    n.st = st_pot; // RULE9
                end
            end
            st_pot:
            begin
                if (!fix_available)
                begin
                    n.st = st_acq;
                    if (!r.stay)
                    begin
                        n.eff_mode = MODE_ONOFF; // RULE10
                    end
                end
            end
            st_inactive:
            begin
                // timer 0 means stay until a pin wakes us
                if (r.tick && (r.sleep_ms != 24'h000000))
                begin
                    n.sleep_ms = r.sleep_ms - 24'h000001;
                end
                if (wake || (r.tick && (r.sleep_ms == 24'h000001)))
                begin
                    n.sleep_ms = 24'h000000;
                    n.epoch_cnt = 16'h0001;
                    // stored mode kept through sleep, so psm resumes as set
                    if ((r.eff_mode == MODE_CONT) && !r.backup)
                    begin
                        n.st = st_cont; // RULE2
                    end
                    else
                    begin
                        n.st = st_acq; // RULE4 RULE13
                    end
                end
            end
            default:
            begin
                n.st = st_cont;
            end
        endcase
        // pin forced-off acts regardless of power save being on
        if (r.foff_en && ext_fell && active)
        begin
            n.st = st_inactive; // RULE6
            n.sleep_ms = 24'h000000;
        end
        // apb: one wait cycle, answer registered
        n.pready = access & ~r.pready;
        n.pslverr = 1'b0;
        if (access && !r.pready)
        begin
            n.pslverr = !hit || wr_err;
            n.prdata = 32'h00000000;
            case (paddr)
                ADDR_CTRL: n.prdata = {27'h0, r.foff_en, r.stay, r.peak, r.cfg_mode};
                ADDR_RATE: n.prdata = {16'h0000, r.measurement_period};
                ADDR_STATUS: n.prdata = {22'h0, r.leap_valid & r.time_valid, r.time_valid,
                    r.cfg_err, r.backup, r.eff_mode, 1'b0, r.st};
                ADDR_TIME: n.prdata = r.local_ms;
                ADDR_LEAP: n.prdata = {24'h000000, r.leap};
                ADDR_GPS: n.prdata = r.gps_ms;
                ADDR_UTC: n.prdata = r.utc_ms;
                default: n.prdata = 32'h00000000;
            endcase
        end
        // writes take effect at the edge that completes the transfer
        if (taken && pwrite)
        begin
            case (paddr)
                ADDR_CTRL:
                begin
                    if (ctrl_ok(pwdata[1:0], r.measurement_period))
                    begin
                        n.cfg_mode = pwdata[1:0];
                        n.eff_mode = pwdata[1:0];
                        n.peak = pwdata[CTRL_PEAK_BIT]; // RULE5
                        n.stay = pwdata[CTRL_STAY_BIT];
                        n.foff_en = pwdata[CTRL_FOFF_BIT];
                        n.cfg_err = 1'b0;
                        if (active)
                        begin
                            n.st = (pwdata[1:0] == MODE_CONT) ? st_cont : st_acq;
                        end
                    end
                    else
                    begin
                        n.cfg_err = 1'b1; // RULE8
                    end
                end
                ADDR_RATE:
                begin
                    if (!wr_err)
                    begin
                        n.measurement_period = pwdata[15:0];
                    end
                end
                ADDR_PMREQ:
                begin
                    // overrides whatever the scheduler was doing
                    n.st = st_inactive; // RULE1 RULE3
                    n.sleep_ms = pwdata[23:0]; // RULE2
                    n.backup = pwdata[PMREQ_BACKUP_BIT]; // RULE13
                end
                ADDR_TIME:
                begin
                    n.local_ms = pwdata; // RULE16
                    n.time_valid = 1'b1;
                end
                ADDR_DRIFT:
                begin
                    n.drift = pwdata[1:0]; // RULE18
                end
                ADDR_LEAP:
                begin
                    n.leap = pwdata[7:0];
                    n.leap_valid = 1'b1; // RULE20
                end
                default:
                begin
                    n.drift = n.drift;
                end
            endcase
        end
        // registered outputs
        n.inactive_o = (n.st == st_inactive);
        n.fixed_o = (n.st == st_acq) && ((n.eff_mode == MODE_ONOFF) || n.backup);
    end

    // state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r <= '0;
            r.measurement_period <= MEASUREMENT_PERIOD_RESET;
            r.leap <= LEAP_DEFAULT;
            r.epoch_cnt <= MEASUREMENT_PERIOD_RESET;
            r.sync1 <= 4'hf;
            r.sync2 <= 4'hf;
            r.prev <= 4'hf;
            r.st <= st_cont;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign ms_tick = r.tick;
    assign nav_epoch = r.epoch;
    assign receiver_inactive = r.inactive_o;
    assign peak_current_limit = r.peak;
    assign fixed_rate_2hz = r.fixed_o;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_power_req_sleep: assert property (taken && pwrite && paddr == ADDR_PMREQ // RULE1
        |=> r.st == st_inactive ##1 receiver_inactive) else $error("request did not sleep");
    a_wake_from_sleep: assert property (r.st == st_inactive && wake && !taken // RULE2
        |=> r.st != st_inactive) else $error("wake did not leave inactive");
    a_resume_save_mode: assert property (r.st == st_inactive && wake && !taken // RULE4
        && r.eff_mode != MODE_CONT |=> r.st == st_acq) else $error("psm not resumed");
    a_peak_limit_out: assert property (taken && pwrite && paddr == ADDR_CTRL && !wr_err // RULE5
        |=> peak_current_limit == $past(pwdata[CTRL_PEAK_BIT])) else $error("peak bit lost");
    a_psm_reject: assert property (taken && wr_err && paddr == ADDR_CTRL // RULE8
        |=> r.cfg_err && r.eff_mode == $past(r.eff_mode)) else $error("bad period accepted");
    a_acq_two_hz: assert property (r.tick && active && r.epoch_cnt <= 16'h0001 // RULE11
        && r.st == st_acq && onoff_like && r.drift == 2'h0 |=> r.epoch_cnt == ACQ_PERIOD_MS)
        else $error("acquisition rate not 2 Hz");
    a_epoch_spacing: assert property (nav_epoch && r.st == st_cont // RULE18
        |-> r.epoch_cnt >= r.measurement_period - 16'h0001 && r.epoch_cnt <= r.measurement_period + 16'h0001)
        else $error("epoch spacing off");
    a_ms_count: assert property (r.tick && !(taken && pwrite && paddr == ADDR_TIME) // RULE15
        |=> r.local_ms == $past(r.local_ms) + 32'h00000001) else $error("local time stalled");
    a_utc_offset: assert property (nav_epoch // RULE19
        |-> r.utc_ms == r.gps_ms - (32'(r.leap) * 32'(MS_PER_S))) else $error("utc mismatch");
    a_wake_ignored: assert property (r.st == st_cont && wake && !taken && !ext_fell // RULE21
        |=> r.st == st_cont) else $error("wake disturbed active state");
    a_tick_divider: assert property (ms_tick // RULE14
        |-> $past(r.div_cnt) == DIV_W'(tick_cycles - 1)) else $error("tick off grid");

    c_sleep_wake: cover property (receiver_inactive ##[1:300] !receiver_inactive);
    c_fallback: cover property (r.st == st_pot ##1 r.eff_mode == MODE_ONOFF);
    c_drift_epoch: cover property (r.drift == DRIFT_MINUS ##[1:1000] nav_epoch);
    c_backup_wake: cover property (r.backup && r.st == st_inactive ##[1:300] r.st == st_acq);
endmodule // pwr_epoch_ctrl
`default_nettype wire

// >>> test/pwr_host_model.sv
/*
 * apb host model driving the power and epoch timing block registers.
 * assumes one clock; the bench calls xfer and waits for it to return.
 */
`default_nettype none
module pwr_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;

    // bus idle from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // setup, then access held until pready is sampled high
    // starts on a fresh edge so a release never meets the next setup
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err, output logic to);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // latency is the slave's business; the bound only cuts a hang
        while (pready !== 1'b1 && n < 32)
        begin
            @(posedge clk);
            n++;
        end
        to = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // pwr_host_model
`default_nettype wire

// >>> test/power_state_and_epoch_timing_tb.sv
/*
 * self-checking bench for the power-state and epoch timing block.
 * assumes the apb host model and a 20-clock reference tick for speed.
 */
`default_nettype none
`define CHK(nm, exp, got) \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
        n_fail++; \
    end
module power_state_and_epoch_timing_tb
    import pwr_epoch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int tc = 20; // short tick keeps epochs affordable
    localparam logic [31:0] f = 32'hffff_ffff; // full compare mask
    logic clk;
    logic srst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ext_pin = 1'b1, rx_pin = 1'b1, cs_n = 1'b1, rst_pin = 1'b1, fix_ok = 1'b0;
    logic ms_tick, nav_epoch, rx_off, peak_lim, rate_2hz;
    logic err, to;
    int n_fail = 0;
    int n_checks = 0;
    int i1, i2;
    // one register access: direction, address, data, mask, expected, error
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, e; logic er;} row_t;
    row_t rows [22] = '{
        '{1'b0, ADDR_CTRL, '0, f, '0, 1'b0},
        '{1'b0, ADDR_RATE, '0, f, 32'(MEASUREMENT_PERIOD_RESET), 1'b0},
        '{1'b0, ADDR_STATUS, '0, 32'h3ff, '0, 1'b0},
        '{1'b0, ADDR_PMREQ, '0, f, '0, 1'b0},
        '{1'b0, 8'h24, '0, f, '0, 1'b1},
        '{1'b1, ADDR_RATE, 32'(MEASUREMENT_PERIOD_HALF_MS), '0, '0, 1'b0},
        '{1'b1, ADDR_CTRL, 32'h1, '0, '0, 1'b0},
        '{1'b1, ADDR_RATE, 32'h5dc, '0, '0, 1'b1},
        '{1'b0, ADDR_RATE, '0, f, 32'(MEASUREMENT_PERIOD_HALF_MS), 1'b0},
        '{1'b1, ADDR_RATE, 32'h2710, '0, '0, 1'b0},
        '{1'b1, ADDR_RATE, 32'h2af8, '0, '0, 1'b1},
        '{1'b1, ADDR_CTRL, '0, '0, '0, 1'b0},
        '{1'b1, ADDR_RATE, 32'h2bc, '0, '0, 1'b0},
        '{1'b1, ADDR_CTRL, 32'h2, '0, '0, 1'b1},
        '{1'b0, ADDR_STATUS, '0, 32'h80, 32'h80, 1'b0},
        '{1'b0, ADDR_CTRL, '0, f, '0, 1'b0},
        '{1'b1, ADDR_RATE, 32'(MEASUREMENT_PERIOD_STEP_MS), '0, '0, 1'b0},
        '{1'b1, ADDR_TIME, 32'h1234, '0, '0, 1'b0},
        '{1'b0, ADDR_TIME, '0, 32'hffff_fff0, 32'h1230, 1'b0},
        '{1'b0, ADDR_STATUS, '0, 32'h300, 32'h100, 1'b0},
        '{1'b1, ADDR_LEAP, 32'h2, '0, '0, 1'b0},
        '{1'b0, ADDR_STATUS, '0, 32'h200, 32'h200, 1'b0}
    };

    // free-running 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    pwr_epoch_ctrl #(.tick_cycles(tc)) dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_interrupt_pin(ext_pin), .serial_rx(rx_pin), .serial_cs_n(cs_n),
        .active_low_reset_pin(rst_pin), .fix_available(fix_ok), .ms_tick(ms_tick),
        .nav_epoch(nav_epoch), .receiver_inactive(rx_off),
        .peak_current_limit(peak_lim), .fixed_rate_2hz(rate_2hz));

    pwr_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // verdict and end of run
    task automatic finish_test();
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one bus access with masked data and error compare
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic [31:0] e, input logic er);
        host.xfer(w, a, d, rd, err, to);
        if (to)
        begin
            n_fail++;
            finish_test();
        end
        `CHK("apb data", e, rd & m)
        `CHK("apb error", er, err)
    endtask

    // wait for inactive (sel 0) or 2 hz flag (sel 1) to reach lvl
    task automatic wait_lvl(input logic sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((sel ? rate_2hz : rx_off) !== lvl && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        `CHK("state level", lvl, sel ? rate_2hz : rx_off)
    endtask

    // the chosen level must stand for every one of cyc cycles
    task automatic hold_lvl(input logic sel, input logic lvl, input int cyc);
        repeat (cyc)
        begin
            @(posedge clk);
            `CHK("held level", lvl, sel ? rate_2hz : rx_off)
        end
    endtask

    // reference ticks counted up to and including the next epoch
    task automatic epoch_gap(output int k);
        int n;
        k = 0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            k += int'(ms_tick === 1'b1);
        end while (nav_epoch !== 1'b1 && n < 25000);
        `CHK("epoch seen", 1'b1, nav_epoch)
    endtask

    // main sequence: local time rate check, then table, then hand-written awkward cases
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        acc(1'b0, ADDR_TIME, '0, '0, '0, 1'b0);
        repeat (96) @(posedge clk);
        acc(1'b0, ADDR_TIME, '0, f, rd + 32'd5, 1'b0);
        foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d, rows[i].m, rows[i].e, rows[i].er);
        // tick spacing in clocks
        i1 = 0;
        i2 = 0;
        while (ms_tick !== 1'b1 && i1 < 50)
        begin
            @(posedge clk);
            i1++;
        end
        do
        begin
            @(posedge clk);
            i2++;
        end while (ms_tick !== 1'b1 && i2 < 50);
        `CHK("tick period", tc, i2)
        // one slip of +1 tick over two one-second epochs
        epoch_gap(i1);
        acc(1'b1, ADDR_DRIFT, 32'(DRIFT_PLUS), '0, '0, 1'b0);
        epoch_gap(i1);
        epoch_gap(i2);
        `CHK("two epoch gaps", 2001, i1 + i2)
        acc(1'b0, ADDR_GPS, '0, '0, '0, 1'b0);
        acc(1'b0, ADDR_UTC, '0, f, rd - 32'd2000, 1'b0);
        // forced off from continuous, wake by serial receive edge
        acc(1'b1, ADDR_PMREQ, '0, '0, '0, 1'b0);
        wait_lvl(1'b0, 1'b1, 8);
        acc(1'b0, ADDR_STATUS, '0, 32'h7, 32'(st_inactive), 1'b0);
        hold_lvl(1'b0, 1'b1, 40);
        @(posedge clk) rx_pin <= 1'b0;
        wait_lvl(1'b0, 1'b0, 8);
        acc(1'b0, ADDR_STATUS, '0, 32'h7, 32'(st_cont), 1'b0);
        @(posedge clk) rx_pin <= 1'b1;
        hold_lvl(1'b0, 1'b0, 10);
        // timed sleep of three ticks
        acc(1'b1, ADDR_PMREQ, 32'h3, '0, '0, 1'b0);
        wait_lvl(1'b0, 1'b1, 8);
        hold_lvl(1'b0, 1'b1, 15);
        wait_lvl(1'b0, 1'b0, 70);
        // on/off power save overruled, reset pin wakes on rising edge only
        acc(1'b1, ADDR_CTRL, 32'h5, '0, '0, 1'b0);
        // the write lands at the completing edge, so look one edge later
        @(posedge clk);
        `CHK("peak limit", 1'b1, peak_lim)
        acc(1'b1, ADDR_PMREQ, '0, '0, '0, 1'b0);
        wait_lvl(1'b0, 1'b1, 8);
        @(posedge clk) rst_pin <= 1'b0;
        hold_lvl(1'b0, 1'b1, 8);
        @(posedge clk) rst_pin <= 1'b1;
        wait_lvl(1'b0, 1'b0, 8);
        wait_lvl(1'b1, 1'b1, 4);
        acc(1'b0, ADDR_STATUS, '0, 32'h37, {26'h0, MODE_ONOFF, 1'b0, st_acq}, 1'b0);
        @(posedge clk) fix_ok <= 1'b1;
        wait_lvl(1'b1, 1'b0, 8);
        // pin forced-off without power save, wake by chip select
        @(posedge clk) fix_ok <= 1'b0;
        acc(1'b1, ADDR_CTRL, 32'h10, '0, '0, 1'b0);
        @(posedge clk) ext_pin <= 1'b0;
        wait_lvl(1'b0, 1'b1, 8);
        @(posedge clk) cs_n <= 1'b0;
        wait_lvl(1'b0, 1'b0, 8);
        @(posedge clk) cs_n <= 1'b1;
        @(posedge clk) ext_pin <= 1'b1;
        hold_lvl(1'b0, 1'b0, 10);
        // software backup wakes into 2 hz acquisition
        acc(1'b1, ADDR_PMREQ, 32'h8000_0000, '0, '0, 1'b0);
        wait_lvl(1'b0, 1'b1, 8);
        acc(1'b0, ADDR_STATUS, '0, 32'h40, 32'h40, 1'b0);
        @(posedge clk) rx_pin <= 1'b0;
        wait_lvl(1'b0, 1'b0, 8);
        wait_lvl(1'b1, 1'b1, 4);
        finish_test();
    end
endmodule // power_state_and_epoch_timing_tb
`default_nettype wire
